//--- hdl/flash_ctrl_params.svh
// constants for the flash program/erase sequencer
`ifndef FLASH_CTRL_PARAMS_SVH
`define FLASH_CTRL_PARAMS_SVH

`define CTRL_OFFSET    8'h00
`define KEY_OFFSET     8'h04
`define PAGE_OFFSET    8'h08
`define ADDR_OFFSET    8'h0c
`define LOW_OFFSET     8'h10
`define HIGH_OFFSET    8'h14
`define STATUS_OFFSET  8'h18

`define RUN_BIT        15
`define ENABLE_BIT     14
`define FAULT_BIT      13
`define ERASE_BIT      6
`define CTRL_RESET     16'h0000

`define KEY_FIRST      8'h55
`define KEY_SECOND     8'haa

`define OP_BULK        4'hf
`define OP_GENERAL     4'hd
`define OP_SECURE      4'hc
`define OP_PAGE        4'h2
`define OP_CONFIG      4'h0
`define OP_WORD        4'h3
`define OP_ROW         4'h1

`define PAGE_MASK      24'hfffc00
`define ROW_MASK       24'hffff80
`define ROW_WORDS      7'h40
`define ADDR_STEP      16'h0002

`define OP_TIME_NS     1435000
`define CLK_PERIOD_NS  10

`define RESP_OKAY      2'h0
`define RESP_DECERR    2'h3

`endif

//--- hdl/flash_ctrl_pkg.sv
// types shared by the flash program/erase sequencer
package flash_ctrl_pkg;

   typedef enum logic [1:0] {KEY_LOCKED, KEY_HALF, KEY_ARMED} key_state_type;
   typedef enum logic {SEQ_IDLE, SEQ_RUN} seq_state_type;

   typedef struct packed {
      logic [7:0]  awaddr;
      logic        awvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        wvalid;
      logic        bready;
      logic [7:0]  araddr;
      logic        arvalid;
      logic        rready;
   } axi_req_type;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic [1:0]  bresp;
      logic        bvalid;
      logic        arready;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        rvalid;
   } axi_resp_type;

   typedef struct packed {
      logic        go;
      logic        erase;
      logic [3:0]  op;
      logic [23:0] addr;
   } flash_cmd_type;

   typedef struct packed {
      logic        valid;
      logic [5:0]  index;
      logic [23:0] data;
   } row_word_type;

   typedef struct packed {
      logic        lowEn;
      logic        highEn;
      logic [5:0]  index;
      logic [15:0] data;
   } buffer_write_type;

   typedef struct packed {
      logic [63:0][23:0] words;
      logic [23:0]       rdData;
   } buffer_state_type;

   typedef struct packed {
      logic             run;
      logic             enable;
      logic             fault;
      logic             erase;
      logic [3:0]       op;
      logic [7:0]       page;
      logic [15:0]      addr;
      key_state_type    key;
      seq_state_type    seq;
      logic [31:0]      timer;
      logic [6:0]       streamLeft;
      logic [5:0]       streamIdx;
      logic             pending;
      logic [5:0]       pendIdx;
      flash_cmd_type    cmd;
      row_word_type     row;
      logic             stall;
      logic             awHeld;
      logic [7:0]       awAddr;
      logic             wHeld;
      logic [31:0]      wData;
      logic [3:0]       wStrb;
      axi_resp_type     resp;
   } ctrl_state_type;

endpackage

//--- hdl/flash_holding_buffer.sv
// 64-word holding buffer filled by table stores, read back by index
`timescale 1ns/100ps
`default_nettype none

module flash_holding_buffer (
   // clock and reset
   input  wire logic                             sys_clk,
   input  wire logic                             rst,
   // table store side
   input  wire flash_ctrl_pkg::buffer_write_type wr,
   // read side, data one cycle after index
   input  wire logic [5:0]                       rdIndex,
   output logic [23:0]                           rdData
);
   import flash_ctrl_pkg::*;

   buffer_state_type state;
   buffer_state_type next_state;

   always_comb begin
      next_state = state;
      // words only land in the buffer, flash is untouched
      if (wr.lowEn) begin
         next_state.words[wr.index][15:0] = wr.data;
      end
      if (wr.highEn) begin
         next_state.words[wr.index][23:16] = wr.data[7:0];
      end
      next_state.rdData = state.words[rdIndex];
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign rdData = state.rdData;

endmodule

`default_nettype wire

//--- hdl/flash_program_erase_control.sv
// flash program/erase sequencer with unlock key, behind an AXI4-Lite slave
//
// Contract
// - improper start attempts or improper termination set the sequence fault flag
// - erase select bit chooses erase or program meaning of the operation code
// - erase codes: bulk, general, secure, page, config byte; 0011/0001 nothing
// - undefined operation codes perform no flash operation
// - key register takes low-byte writes, write-only, upper byte reads zero
// - key 0x55 then 0xAA consecutively must precede a start
// - processor stalls for the whole cycle, resumes when it ends
// - row program needs 64 words loaded into holding buffers first
// - pages align on 1536-byte and rows on 192-byte boundaries
`timescale 1ns/100ps
`default_nettype none
`include "flash_ctrl_params.svh"

module flash_program_erase_control #(
   parameter int unsigned OP_CYCLES =
      (`OP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
   // clock and reset
   input  wire logic                         sys_clk,
   input  wire logic                         rst,
   // register bus
   input  wire flash_ctrl_pkg::axi_req_type  axiReq,
   output flash_ctrl_pkg::axi_resp_type      axiResp,
   // flash array side
   input  wire logic                         flashFault,
   output flash_ctrl_pkg::flash_cmd_type     flashCmd,
   output flash_ctrl_pkg::row_word_type      rowWord,
   // processor side
   output logic                              coreStall
);
   import flash_ctrl_pkg::*;

   ctrl_state_type   state;
   ctrl_state_type   next_state;
   buffer_write_type bufWrite;
   logic [23:0]      bufData;

   localparam logic [15:0] CTRL_INIT = `CTRL_RESET;

   ////////////////////////////////////////////////////////////////////////////

   function automatic logic opPerforms(input logic erase, input logic [3:0] op);
      if (erase) begin
         opPerforms = (op == `OP_BULK) || (op == `OP_GENERAL) ||
                      (op == `OP_SECURE) || (op == `OP_PAGE) || (op == `OP_CONFIG);
      end else begin
         opPerforms = (op == `OP_WORD) || (op == `OP_ROW) || (op == `OP_CONFIG);
      end
   endfunction

   // operation shapes that change addressing or streaming
   function automatic logic isPageErase(input logic erase, input logic [3:0] op);
      isPageErase = erase && (op == `OP_PAGE);
   endfunction

   function automatic logic isRowProgram(input logic erase, input logic [3:0] op);
      isRowProgram = !erase && (op == `OP_ROW);
   endfunction

   // holding-buffer slot of a table offset: one slot per instruction, two address units
   function automatic logic [5:0] slotOf(input logic [15:0] addr);
      slotOf = addr[6:1];
   endfunction

   function automatic logic [23:0] alignAddr(input logic erase, input logic [3:0] op,
                                             input logic [23:0] addr);
      if (isPageErase(erase, op)) begin
         alignAddr = addr & `PAGE_MASK;
      end else if (isRowProgram(erase, op)) begin
         alignAddr = addr & `ROW_MASK;
      end else begin
         alignAddr = addr;
      end
   endfunction

   function automatic logic [15:0] ctrlImage(input ctrl_state_type s);
      ctrlImage = 16'h0000;
      ctrlImage[`RUN_BIT] = s.run;
      ctrlImage[`ENABLE_BIT] = s.enable;
      ctrlImage[`FAULT_BIT] = s.fault;
      ctrlImage[`ERASE_BIT] = s.erase;
      ctrlImage[3:0] = s.op;
   endfunction

   ////////////////////////////////////////////////////////////////////////////

   flash_holding_buffer buffer (
      .sys_clk (sys_clk),
      .rst     (rst),
      .wr      (bufWrite),
      .rdIndex (state.streamIdx),
      .rdData  (bufData)
   );

   ////////////////////////////////////////////////////////////////////////////

   always_comb begin
      logic        doWrite;
      logic [7:0]  wa;
      logic [31:0] wd;
      logic [3:0]  ws;
      logic        startReq;
      next_state = state;
      bufWrite = '0;
      doWrite = 1'b0;
      wa = state.awAddr;
      wd = state.wData;
      ws = state.wStrb;
      startReq = 1'b0;
      next_state.cmd.go = 1'b0;

      // write address and data are taken independently
      if (axiReq.awvalid && state.resp.awready) begin
         next_state.awHeld = 1'b1;
         next_state.awAddr = axiReq.awaddr;
      end
      if (axiReq.wvalid && state.resp.wready) begin
         next_state.wHeld = 1'b1;
         next_state.wData = axiReq.wdata;
         next_state.wStrb = axiReq.wstrb;
      end
      if (state.resp.bvalid && axiReq.bready) begin
         next_state.resp.bvalid = 1'b0;
      end
      if (state.awHeld && state.wHeld && !state.resp.bvalid) begin
         doWrite = 1'b1;
         next_state.awHeld = 1'b0;
         next_state.wHeld = 1'b0;
         next_state.resp.bvalid = 1'b1;
         next_state.resp.bresp = `RESP_OKAY;
      end

      if (doWrite) begin
         // any write other than a key step breaks the unlock sequence
         next_state.key = KEY_LOCKED;
         if (wa == `CTRL_OFFSET) begin
            if (state.seq == SEQ_IDLE) begin
               if (ws[0]) begin
                  next_state.erase = wd[`ERASE_BIT];
                  next_state.op = wd[3:0];
               end
               if (ws[1]) begin
                  next_state.enable = wd[`ENABLE_BIT];
                  next_state.fault = wd[`FAULT_BIT];
                  startReq = wd[`RUN_BIT];
               end
            end
         end else if (wa == `KEY_OFFSET) begin
            if (ws[0]) begin
               if (wd[7:0] == `KEY_FIRST) begin
                  next_state.key = KEY_HALF;
               end else if (wd[7:0] == `KEY_SECOND && state.key == KEY_HALF) begin
                  next_state.key = KEY_ARMED;
               end
            end
         end else if (wa == `PAGE_OFFSET) begin
            if (ws[0]) begin
               next_state.page = wd[7:0];
            end
         end else if (wa == `ADDR_OFFSET) begin
            if (ws[0]) begin
               next_state.addr[7:0] = wd[7:0];
            end
            if (ws[1]) begin
               next_state.addr[15:8] = wd[15:8];
            end
         end else if (wa == `LOW_OFFSET) begin
            bufWrite.lowEn = state.seq == SEQ_IDLE;
            bufWrite.index = slotOf(state.addr);
            bufWrite.data = wd[15:0];
         end else if (wa == `HIGH_OFFSET) begin
            bufWrite.highEn = state.seq == SEQ_IDLE;
            bufWrite.index = slotOf(state.addr);
            bufWrite.data = {8'h00, wd[7:0]};
            next_state.addr = state.addr + `ADDR_STEP;
         end else begin
            next_state.resp.bresp = `RESP_DECERR;
         end
      end

      // start attempt
      if (startReq) begin
         if (state.key != KEY_ARMED || !next_state.enable) begin
            next_state.fault = 1'b1;
         end else if (opPerforms(next_state.erase, next_state.op)) begin
            next_state.run = 1'b1;
            next_state.seq = SEQ_RUN;
            next_state.stall = 1'b1;
            next_state.timer = OP_CYCLES;
            next_state.cmd.go = 1'b1;
            next_state.cmd.erase = next_state.erase;
            next_state.cmd.op = next_state.op;
            next_state.cmd.addr = alignAddr(next_state.erase, next_state.op,
                                            {state.page, state.addr});
            if (isRowProgram(next_state.erase, next_state.op)) begin
               next_state.streamLeft = `ROW_WORDS;
               next_state.streamIdx = 6'h00;
            end else if (!next_state.erase) begin
               next_state.streamLeft = 7'h01;
               next_state.streamIdx = slotOf(state.addr);
            end
         end
      end

      // self-timed cycle, streaming buffer words to the array
      next_state.pending = 1'b0;
      next_state.row.valid = state.pending;
      next_state.row.index = state.pendIdx;
      next_state.row.data = bufData;
      if (state.seq == SEQ_RUN) begin
         next_state.timer = state.timer - 32'h1;
         if (state.streamLeft != 7'h00) begin
            next_state.pending = 1'b1;
            next_state.pendIdx = state.streamIdx;
            next_state.streamIdx = state.streamIdx + 6'h01;
            next_state.streamLeft = state.streamLeft - 7'h01;
         end
         // normal end or array abort; either way the key must be given again
         if (state.timer == 32'h1 || flashFault) begin
            next_state.run = 1'b0;
            next_state.seq = SEQ_IDLE;
            next_state.stall = 1'b0;
            next_state.streamLeft = 7'h00;
            next_state.key = KEY_LOCKED;
            if (flashFault) begin
               next_state.fault = 1'b1;
            end
         end
      end

      // read channel
      if (state.resp.rvalid && axiReq.rready) begin
         next_state.resp.rvalid = 1'b0;
      end
      if (axiReq.arvalid && state.resp.arready) begin
         next_state.resp.rvalid = 1'b1;
         next_state.resp.rresp = `RESP_OKAY;
         next_state.resp.rdata = 32'h0;
         if (axiReq.araddr == `CTRL_OFFSET) begin
            next_state.resp.rdata[15:0] = ctrlImage(state);
         end else if (axiReq.araddr == `KEY_OFFSET) begin
            next_state.resp.rdata = 32'h0;
         end else if (axiReq.araddr == `PAGE_OFFSET) begin
            next_state.resp.rdata[7:0] = state.page;
         end else if (axiReq.araddr == `ADDR_OFFSET) begin
            next_state.resp.rdata[15:0] = state.addr;
         end else if (axiReq.araddr == `LOW_OFFSET || axiReq.araddr == `HIGH_OFFSET) begin
            next_state.resp.rdata = 32'h0;
         end else if (axiReq.araddr == `STATUS_OFFSET) begin
            next_state.resp.rdata[0] = state.seq == SEQ_RUN;
            next_state.resp.rdata[2:1] = state.key;
         end else begin
            next_state.resp.rresp = `RESP_DECERR;
         end
      end

      next_state.resp.awready = !next_state.awHeld;
      next_state.resp.wready = !next_state.wHeld;
      next_state.resp.arready = !next_state.resp.rvalid;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state <= '0;
         state.key <= KEY_LOCKED;
         state.seq <= SEQ_IDLE;
         state.resp.awready <= 1'b1;
         state.resp.wready <= 1'b1;
         state.resp.arready <= 1'b1;
         // control bits come up from the control reset word
         state.run <= CTRL_INIT[`RUN_BIT];
         state.enable <= CTRL_INIT[`ENABLE_BIT];
         state.fault <= CTRL_INIT[`FAULT_BIT];
         state.erase <= CTRL_INIT[`ERASE_BIT];
         state.op <= CTRL_INIT[3:0];
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////

   assign axiResp = state.resp;
   assign flashCmd = state.cmd;
   assign rowWord = state.row;
   assign coreStall = state.stall;

endmodule

`default_nettype wire

//--- testbench/flash_program_erase_control_assertions.sv
// concurrent checks on the flash sequencer ports
`timescale 1ns/100ps
`default_nettype none
`include "flash_ctrl_params.svh"

module flash_program_erase_control_assertions
   import flash_ctrl_pkg::*;
#(
   parameter int unsigned OP_CYCLES = 100
) (
   // clock and reset
   input wire logic                         sys_clk,
   input wire logic                         rst,
   // register bus
   input wire flash_ctrl_pkg::axi_req_type  axiReq,
   input wire flash_ctrl_pkg::axi_resp_type axiResp,
   // flash array and core
   input wire logic                         flashFault,
   input wire flash_ctrl_pkg::flash_cmd_type flashCmd,
   input wire flash_ctrl_pkg::row_word_type rowWord,
   input wire logic                         coreStall
);
   logic [31:0] stallCnt;

   always_ff @(posedge sys_clk) begin
      if (rst) stallCnt <= 32'h0;
      else stallCnt <= coreStall ? stallCnt + 32'h1 : 32'h0;
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   a_go_pulse: assert property (flashCmd.go |=> !flashCmd.go)
      else $error("launch pulse longer than one cycle");
   a_go_stall: assert property (flashCmd.go |-> $rose(coreStall))
      else $error("launch without fresh stall");
   a_stall_go: assert property ($rose(coreStall) |-> flashCmd.go)
      else $error("stall without launch");
   a_stall_len: assert property ($fell(coreStall) |->
      stallCnt == OP_CYCLES || $past(flashFault) || $past(flashFault, 2))
      else $error("cycle ended at wrong time");
   a_stall_max: assert property (coreStall |-> stallCnt < OP_CYCLES)
      else $error("stall outlasts cycle");
   a_code_legal: assert property (flashCmd.go |-> (flashCmd.erase ?
      flashCmd.op inside {`OP_BULK, `OP_GENERAL, `OP_SECURE, `OP_PAGE, `OP_CONFIG} :
      flashCmd.op inside {`OP_WORD, `OP_ROW, `OP_CONFIG}))
      else $error("launch of undefined code");
   a_row_first: assert property (flashCmd.go && !flashCmd.erase && flashCmd.op == `OP_ROW
      |-> ##[1:4] (rowWord.valid && rowWord.index == 6'h00))
      else $error("row stream did not start");
   a_row_next: assert property (coreStall && rowWord.valid && rowWord.index != 6'h3f
      && !flashCmd.erase && flashCmd.op == `OP_ROW |=> rowWord.valid
      && rowWord.index == $past(rowWord.index) + 6'h01)
      else $error("row stream broken");
   a_erase_quiet: assert property (coreStall && flashCmd.erase |-> !rowWord.valid)
      else $error("word streamed during erase");
   a_bvalid_hold: assert property (axiResp.bvalid && !axiReq.bready |=> axiResp.bvalid)
      else $error("write response dropped");
endmodule

bind flash_program_erase_control flash_program_erase_control_assertions #(
   .OP_CYCLES(OP_CYCLES)
) i_chk (
   .sys_clk(sys_clk), .rst(rst), .axiReq(axiReq), .axiResp(axiResp),
   .flashFault(flashFault), .flashCmd(flashCmd), .rowWord(rowWord), .coreStall(coreStall)
);
`default_nettype wire

//--- testbench/flash_array_model.sv
// flash array stand-in: records launches and row words, injects faults
`timescale 1ns/100ps
`default_nettype none

module flash_array_model
   import flash_ctrl_pkg::*;
(
   // clock
   input  wire logic                          sys_clk,
   // sequencer side
   input  wire flash_ctrl_pkg::flash_cmd_type flashCmd,
   input  wire flash_ctrl_pkg::row_word_type  rowWord,
   output logic                               flashFault,
   // bench side
   input  wire logic                          faultReq,
   output int                                 goCount,
   output int                                 wordCount,
   output flash_ctrl_pkg::flash_cmd_type      lastCmd,
   output logic [63:0][23:0]                  words
);
   initial begin
      goCount = 0;
      wordCount = 0;
      flashFault = 1'b0;
   end

   always @(posedge sys_clk) begin
      flashFault <= faultReq;
      if (flashCmd.go) begin
         goCount <= goCount + 1;
         lastCmd <= flashCmd;
      end
      if (rowWord.valid) begin
         wordCount <= wordCount + 1;
         words[rowWord.index] <= rowWord.data;
      end
   end
endmodule
`default_nettype wire

//--- testbench/flash_program_erase_control_tb_top.sv
// self-checking bench for the flash program/erase sequencer
`timescale 1ns/100ps
`default_nettype none
`include "flash_ctrl_params.svh"

module flash_program_erase_control_tb_top;
   import flash_ctrl_pkg::*;
   localparam int unsigned OPC = 100;
   logic              sys_clk = 1'b0;
   logic              rst = 1'b1;
   axi_req_type       axiReq = '{bready: 1'b1, rready: 1'b1, default: '0};
   axi_resp_type      axiResp;
   logic              flashFault;
   logic              faultReq = 1'b0;
   flash_cmd_type     flashCmd;
   row_word_type      rowWord;
   logic              coreStall;
   int                goCount;
   int                wordCount;
   flash_cmd_type     lastCmd;
   logic [63:0][23:0] words;
   int                error_cnt = 0;
   int                checks_done = 0;
   logic [31:0]       rd;
   logic [1:0]        rsp;
   int                g;
   logic              legal;
   logic [15:0]       ctrl;

   flash_program_erase_control #(.OP_CYCLES(OPC)) i_dut (
      .sys_clk(sys_clk), .rst(rst), .axiReq(axiReq), .axiResp(axiResp),
      .flashFault(flashFault), .flashCmd(flashCmd), .rowWord(rowWord), .coreStall(coreStall));
   flash_array_model i_array (
      .sys_clk(sys_clk), .flashCmd(flashCmd), .rowWord(rowWord), .flashFault(flashFault),
      .faultReq(faultReq), .goCount(goCount), .wordCount(wordCount), .lastCmd(lastCmd),
      .words(words));

   initial forever #5 sys_clk = ~sys_clk;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic summarize;
      if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tmo(input int n);
      if (n >= 200) begin
         chk(32'(n), 32'h0);
         summarize();
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      axiReq.awaddr <= a;
      axiReq.wdata <= d;
      axiReq.wstrb <= 4'hf;
      axiReq.awvalid <= 1'b1;
      axiReq.wvalid <= 1'b1;
      axiReq.bready <= 1'b0;
      do begin
         @(posedge sys_clk);
         n++;
         if (axiResp.awready) axiReq.awvalid <= 1'b0;
         if (axiResp.wready) axiReq.wvalid <= 1'b0;
      end while (!axiResp.bvalid && n < 200);
      // response taken one edge late, so the slave must hold it
      axiReq.bready <= 1'b1;
      @(posedge sys_clk);
      tmo(n);
      rsp = axiResp.bresp;
   endtask
   task automatic axr(input logic [7:0] a);
      int n = 0;
      axiReq.araddr <= a;
      axiReq.arvalid <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
         if (axiResp.arready) axiReq.arvalid <= 1'b0;
      end while (!axiResp.rvalid && n < 200);
      tmo(n);
      rd = axiResp.rdata;
      rsp = axiResp.rresp;
   endtask
   task automatic launch(input logic [15:0] c);
      axw(`CTRL_OFFSET, {16'h0, c});
      axw(`KEY_OFFSET, 32'h55);
      axw(`KEY_OFFSET, 32'haa);
      axw(`CTRL_OFFSET, {16'h0, c | 16'h8000});
      repeat (2) @(posedge sys_clk);
   endtask
   task automatic settle;
      int n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (coreStall !== 1'b0 && n < 200);
      tmo(n);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      axr(`CTRL_OFFSET);
      chk(rd, 32'h0);
      axw(`KEY_OFFSET, 32'h55);
      axr(`KEY_OFFSET);
      chk(rd, 32'h0);
      axr(`STATUS_OFFSET);
      chk(rd, 32'h2);
      axw(`KEY_OFFSET, 32'haa);
      axr(`STATUS_OFFSET);
      chk(rd, 32'h4);
      // improper starts: no unlock, enable clear, interrupted key pair
      g = goCount;
      axw(`CTRL_OFFSET, 32'h4042);
      axw(`CTRL_OFFSET, 32'hc042);
      axr(`CTRL_OFFSET);
      chk(rd, 32'h6042);
      axw(`CTRL_OFFSET, 32'h0);
      launch(16'h0042);
      axr(`CTRL_OFFSET);
      chk(rd, 32'h2042);
      axw(`CTRL_OFFSET, 32'h0);
      axw(`KEY_OFFSET, 32'h55);
      axw(`PAGE_OFFSET, 32'h0);
      axw(`KEY_OFFSET, 32'haa);
      axw(`CTRL_OFFSET, 32'hc042);
      axr(`CTRL_OFFSET);
      chk(rd, 32'h6042);
      chk(32'(goCount - g), 32'h0);
      // every code in both modes
      axw(`PAGE_OFFSET, 32'h01);
      axw(`ADDR_OFFSET, 32'h0600);
      axw(`LOW_OFFSET, 32'h0);
      for (int e = 0; e < 2; e++) begin
         for (int op = 0; op < 16; op++) begin
            ctrl = {1'b0, 1'b1, 7'h00, 1'(e), 2'b00, 4'(op)};
            legal = e ? (op inside {15, 13, 12, 2, 0}) : (op inside {3, 1, 0});
            g = goCount;
            launch(ctrl);
            settle();
            chk(32'(goCount - g), {31'h0, legal});
            axr(`CTRL_OFFSET);
            chk(rd, {16'h0, ctrl});
            if (e == 1 && op == 2) chk({8'h0, lastCmd.addr}, 32'h010400);
         end
      end
      // row program from a loaded buffer
      axw(`PAGE_OFFSET, 32'h0);
      axw(`ADDR_OFFSET, 32'h6000);
      for (int k = 0; k < 64; k++) begin
         axw(`LOW_OFFSET, 32'h5a00 + k);
         axw(`HIGH_OFFSET, 32'h80 + k);
      end
      axr(`ADDR_OFFSET);
      chk(rd, 32'h6080);
      axw(`ADDR_OFFSET, 32'h6000);
      g = wordCount;
      launch(16'h4001);
      settle();
      chk(32'(wordCount - g), 32'd64);
      chk({8'h0, lastCmd.addr}, 32'h6000);
      for (int k = 0; k < 64; k++) begin
         chk({8'h0, words[k]}, {8'h0, 8'(8'h80 + k), 16'(16'h5a00 + k)});
      end
      // next row of the same page, buffer reused
      axw(`ADDR_OFFSET, 32'h6080);
      launch(16'h4001);
      settle();
      chk({8'h0, lastCmd.addr}, 32'h6080);
      // array fault in mid cycle
      launch(16'h404f);
      axr(`STATUS_OFFSET);
      chk(rd, 32'h1);
      repeat (5) @(posedge sys_clk);
      faultReq <= 1'b1;
      @(posedge sys_clk);
      faultReq <= 1'b0;
      settle();
      axr(`CTRL_OFFSET);
      chk(rd, 32'h604f);
      // unmapped place
      axr(8'h1c);
      chk({30'h0, rsp}, {30'h0, `RESP_DECERR});
      axw(8'h1c, 32'hffff);
      chk({30'h0, rsp}, {30'h0, `RESP_DECERR});
      summarize();
   end
endmodule
`default_nettype wire
